// file: core/acl_pkg.sv
package acl_pkg;

  // Access classes seen by the checker.
  typedef enum logic [3:0] {
    ACL_BYTE,
    ACL_HALF,
    ACL_WORD,
    ACL_TBH,
    ACL_EXCL_HALF,
    ACL_EXCL_WORD,
    ACL_DOUBLE,
    ACL_MULTI,
    ACL_STACK,
    ACL_COPROC
  } acl_class_type;

  // Program counter update kinds.
  typedef enum logic [2:0] {
    ACL_PC_NONE,
    ACL_PC_ADDMOV16,
    ACL_PC_INTERWORK,
    ACL_PC_VECTOR,
    ACL_PC_EXCEPTION_RETURN_CODE
  } acl_pc_type;

  // Byte reverse operations.
  typedef enum logic [1:0] {
    ACL_REV_NONE,
    ACL_REV_WORD,
    ACL_REV_SIGNED_HALF,
    ACL_REV_PACKED_HALVES
  } acl_rev_type;

  typedef struct packed {
    logic          valid;
    logic          is_load;
    acl_class_type cls;
    logic [31:0]   addr;
    logic [31:0]   wdata;
  } acl_req_type;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic        perform;
    logic [3:0]  lanes;
    logic [31:0] data;
  } acl_rsp_type;

  localparam logic [31:0] ACL_SCS_BASE    = 32'hE000_E000;
  localparam logic [31:0] ACL_SCS_MASK    = 32'hFFFF_F000;
  localparam logic [3:0]  ACL_LANES_NONE  = 4'h0;
  localparam logic [3:0]  ACL_LANES_BYTE  = 4'h1;
  localparam logic [3:0]  ACL_LANES_HALF  = 4'h3;
  localparam logic [3:0]  ACL_LANES_WORD  = 4'hF;
  localparam logic [27:0] ACL_EXCRET_TOP  = 28'hFFF_FFFF;
  localparam logic [3:0]  ACL_EXCRET_HND  = 4'h1;
  localparam logic [3:0]  ACL_EXCRET_MSP  = 4'h9;
  localparam logic [3:0]  ACL_EXCRET_PSP  = 4'hD;
  localparam logic [31:0] ACL_ZERO_WORD   = 32'h0000_0000;

endpackage

// file: core/acl_core.sv
`timescale 1ns/10ps
// How it works
// - Exclusive, double, multiple, stack, coprocessor unaligned always fault.
// - Ordinary unaligned accesses complete unless trap enabled.
// - Misalignment fault sets unaligned flag, usage fault.
// - Trap enable faults every unaligned data access.
// - Instruction fetch addresses are halfword aligned.
// - Vector with bit zero clear: invalid state.
// - Reserved return code loaded: invalid PC fault.
// - Sixteen-bit add/move drops PC bit zero.
// - Interworking PC load with bit zero clear faults.
// - Word access touches bytes A to A+3.
// - Little endian: low address byte in bits 7:0.
// - Big endian: low address byte most significant.
// - Endianness sampled from input at reset release.
// - Instruction fetches always little endian.
// - System control space accesses always little endian.
// - Wide instruction is two halfwords, lower first.
// - Byte swap applies per transferred element size.
// - Full word byte reverse.
// - Swap low bytes and sign extend.
// - Swap bytes within each halfword.
module acl_core
  import acl_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        big_endian_mode_i,
  input  wire logic        unaligned_trap_enable_i,
  input  wire acl_req_type req_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [31:0] fetch_addr_i,
  input  wire logic [31:0] fetch_data_i,
  input  wire acl_pc_type  pc_kind_i,
  input  wire logic [31:0] pc_value_i,
  input  wire acl_rev_type rev_op_i,
  input  wire logic [31:0] rev_src_i,
  output acl_rsp_type      rsp_o,
  output logic             unaligned_fault_o,
  output logic             usage_fault_exception_o,
  output logic             invalid_state_fault_o,
  output logic             invalid_pc_fault_o,
  output logic             fetch_fault_o,
  output logic [31:0]      pc_next_o,
  output logic             pc_valid_o,
  output logic [15:0]      first_halfword_o,
  output logic [15:0]      second_halfword_o,
  output logic [31:0]      rev_result_o,
  output logic             big_endian_mode_o
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  function automatic logic [31:0] swap_word(input logic [31:0] v);
    swap_word = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [15:0] swap_half(input logic [15:0] v);
    swap_half = {v[7:0], v[15:8]};
  endfunction

  function automatic logic misaligned(input acl_class_type c,
                                      input logic [1:0]    a);
    unique case (c)
      ACL_BYTE:                 misaligned = 1'b0;
      ACL_HALF, ACL_TBH,
      ACL_EXCL_HALF:            misaligned = a[0];
      default:                  misaligned = |a;
    endcase
  endfunction

  function automatic logic aligned_only(input acl_class_type c);
    unique case (c)
      ACL_EXCL_HALF, ACL_EXCL_WORD, ACL_DOUBLE,
      ACL_MULTI, ACL_STACK, ACL_COPROC: aligned_only = 1'b1;
      default:                          aligned_only = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Endian strap capture
  // ==========================================================
  logic endian_q;
  logic endian_d;
  logic strap_done_q;
  logic strap_done_d;

  always_comb begin
    endian_d     = endian_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      endian_d = big_endian_mode_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      endian_q     <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (ce_i) begin
      endian_q     <= endian_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ==========================================================
  // Data access checking and lane mapping
  // ==========================================================
  acl_rsp_type rsp_q;
  acl_rsp_type rsp_d;
  logic        unal_q;
  logic        unal_d;
  logic        uf_q;
  logic        uf_d;
  logic        is_mis;
  logic        do_fault;
  logic        use_be;
  logic [31:0] raw;

  always_comb begin
    is_mis   = misaligned(req_i.cls, req_i.addr[1:0]);
    // Aligned-only classes fault regardless; others only with trap.
    do_fault = is_mis && (aligned_only(req_i.cls)
               || unaligned_trap_enable_i);
    use_be   = endian_q &&
               ((req_i.addr & ACL_SCS_MASK) != ACL_SCS_BASE);
    raw      = req_i.is_load ? rdata_i : req_i.wdata;
    rsp_d          = '0;
    rsp_d.valid    = req_i.valid;
    rsp_d.fault    = req_i.valid && do_fault;
    rsp_d.perform  = req_i.valid && !do_fault;
    rsp_d.lanes    = ACL_LANES_NONE;
    rsp_d.data     = ACL_ZERO_WORD;
    if (req_i.valid && !do_fault) begin
      // Lanes are relative to A; a word spans A..A+3.
      unique case (req_i.cls)
        ACL_BYTE: begin
          rsp_d.lanes = ACL_LANES_BYTE;
          rsp_d.data  = {24'h00_0000, raw[7:0]};
        end
        ACL_HALF, ACL_TBH, ACL_EXCL_HALF: begin
          rsp_d.lanes = ACL_LANES_HALF;
          rsp_d.data  = {16'h0000, use_be ? swap_half(raw[15:0])
                                          : raw[15:0]};
        end
        default: begin
          rsp_d.lanes = ACL_LANES_WORD;
          rsp_d.data  = use_be ? swap_word(raw) : raw;
        end
      endcase
    end
    unal_d = req_i.valid && do_fault;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_q  <= '0;
      unal_q <= 1'b0;
    end else if (ce_i) begin
      rsp_q  <= rsp_d;
      unal_q <= unal_d;
    end
  end

  // ==========================================================
  // Program counter and fetch checks
  // ==========================================================
  logic        invst_q;
  logic        invst_d;
  logic        invalid_pc_fault_q;
  logic        invalid_pc_fault_d;
  logic        ffault_q;
  logic        ffault_d;
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic        pcv_q;
  logic        pcv_d;
  logic [15:0] hw1_q;
  logic [15:0] hw1_d;
  logic [15:0] hw2_q;
  logic [15:0] hw2_d;
  logic        reserved_ret;

  always_comb begin
    reserved_ret = (pc_value_i[31:4] == ACL_EXCRET_TOP) &&
                   (pc_value_i[3:0] != ACL_EXCRET_HND) &&
                   (pc_value_i[3:0] != ACL_EXCRET_MSP) &&
                   (pc_value_i[3:0] != ACL_EXCRET_PSP);
    invst_d = 1'b0;
    invalid_pc_fault_d = 1'b0;
    pcv_d   = 1'b0;
    pc_d    = pc_q;
    unique case (pc_kind_i)
      ACL_PC_NONE: begin
        pcv_d = 1'b0;
      end
      ACL_PC_ADDMOV16: begin
        pcv_d = 1'b1;
        pc_d  = {pc_value_i[31:1], 1'b0};
      end
      ACL_PC_INTERWORK: begin
        invst_d = !pc_value_i[0];
        pcv_d   = pc_value_i[0];
        pc_d    = {pc_value_i[31:1], 1'b0};
      end
      ACL_PC_VECTOR: begin
        invst_d = !pc_value_i[0];
        pcv_d   = pc_value_i[0];
        pc_d    = {pc_value_i[31:1], 1'b0};
      end
      ACL_PC_EXCEPTION_RETURN_CODE: begin
        invalid_pc_fault_d = reserved_ret;
        pcv_d   = 1'b0;
      end
      default: begin
        pcv_d = 1'b0;
      end
    endcase
    ffault_d = fetch_valid_i && fetch_addr_i[0];
    // Fetch data stays little endian.
    hw1_d = hw1_q;
    hw2_d = hw2_q;
    if (fetch_valid_i && !fetch_addr_i[0]) begin
      hw1_d = fetch_data_i[15:0];
      hw2_d = fetch_data_i[31:16];
    end
    uf_d = unal_d || invst_d || invalid_pc_fault_d || ffault_d;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      invst_q  <= 1'b0;
      invalid_pc_fault_q  <= 1'b0;
      ffault_q <= 1'b0;
      pc_q     <= ACL_ZERO_WORD;
      pcv_q    <= 1'b0;
      hw1_q    <= 16'h0000;
      hw2_q    <= 16'h0000;
      uf_q     <= 1'b0;
    end else if (ce_i) begin
      invst_q  <= invst_d;
      invalid_pc_fault_q  <= invalid_pc_fault_d;
      ffault_q <= ffault_d;
      pc_q     <= pc_d;
      pcv_q    <= pcv_d;
      hw1_q    <= hw1_d;
      hw2_q    <= hw2_d;
      uf_q     <= uf_d;
    end
  end

  // ==========================================================
  // Byte reverse unit
  // ==========================================================
  logic [31:0] rev_q;
  logic [31:0] rev_d;

  always_comb begin
    rev_d = rev_q;
    unique case (rev_op_i)
      ACL_REV_NONE:          rev_d = rev_q;
      ACL_REV_WORD:          rev_d = swap_word(rev_src_i);
      ACL_REV_SIGNED_HALF:   rev_d = {{16{rev_src_i[7]}},
                                      swap_half(rev_src_i[15:0])};
      ACL_REV_PACKED_HALVES: rev_d = {swap_half(rev_src_i[31:16]),
                                      swap_half(rev_src_i[15:0])};
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rev_q <= ACL_ZERO_WORD;
    end else if (ce_i) begin
      rev_q <= rev_d;
    end
  end

  assign rsp_o                   = rsp_q;
  assign unaligned_fault_o       = unal_q;
  assign usage_fault_exception_o = uf_q;
  assign invalid_state_fault_o   = invst_q;
  assign invalid_pc_fault_o      = invalid_pc_fault_q;
  assign fetch_fault_o           = ffault_q;
  assign pc_next_o               = pc_q;
  assign pc_valid_o              = pcv_q;
  assign first_halfword_o        = hw1_q;
  assign second_halfword_o       = hw2_q;
  assign rev_result_o            = rev_q;
  assign big_endian_mode_o       = endian_q;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  excl_fault_a: assert property (ce_i && req_i.valid &&
    req_i.cls == ACL_EXCL_WORD && req_i.addr[1:0] != 2'b00
    |=> rsp_o.fault && unaligned_fault_o)
    else $error("unaligned exclusive word did not fault");

  plain_unal_a: assert property (ce_i && req_i.valid &&
    req_i.cls == ACL_WORD && !unaligned_trap_enable_i
    |=> rsp_o.perform && !rsp_o.fault)
    else $error("ordinary word access wrongly faulted");

  flag_exc_a: assert property (unaligned_fault_o
    |-> usage_fault_exception_o)
    else $error("unaligned fault without usage fault");

  trap_all_a: assert property (ce_i && req_i.valid &&
    unaligned_trap_enable_i && req_i.cls == ACL_HALF && req_i.addr[0]
    |=> rsp_o.fault)
    else $error("trap enable did not fault halfword");

  vector_bit_a: assert property (ce_i && pc_kind_i == ACL_PC_VECTOR &&
    !pc_value_i[0] |=> invalid_state_fault_o && !pc_valid_o)
    else $error("bad vector not flagged");

  addmov_drop_a: assert property (ce_i &&
    pc_kind_i == ACL_PC_ADDMOV16
    |=> pc_valid_o && !pc_next_o[0] && !invalid_state_fault_o)
    else $error("add/move PC write mishandled");

  rev_word_a: assert property (ce_i && rev_op_i == ACL_REV_WORD
    |=> rev_result_o[7:0] == $past(rev_src_i[31:24]))
    else $error("word reverse wrong");

  fault_quiet_a: assert property (rsp_o.fault
    |-> !rsp_o.perform && rsp_o.lanes == ACL_LANES_NONE)
    else $error("faulting access still transfers");

endmodule

// file: dv/acl_mem_model.sv
`timescale 1ns/10ps
// Memory that answers a load in the cycle of its request.
// All of it is normal memory, so no ordered or device access arises.
module acl_mem_model
  import acl_pkg::*;
(
  input  wire acl_req_type req_i,
  output logic [31:0]      rdata_o
);
  always_comb begin
    rdata_o = ~req_i.addr;
    if (req_i.valid) begin
      for (int k = 0; k < 4; k++) begin
        rdata_o[8*k+:8] = 8'(req_i.addr + k) ^ 8'hA5;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import acl_pkg::*;
;
  typedef struct packed {
    acl_rsp_type rsp;
    logic [4:0]  flg;
    logic [31:0] byte_reverse_word;
    logic [31:0] hw;
    logic [31:0] pc;
    logic        pcv;
    logic        pck;
  } acl_exp_type;
  logic        mclk_i = 0;
  logic        resetn_i = 0;
  logic        be_i = 0;
  logic        be_s = 0;
  logic        trap_i = 0;
  logic        fv = 0;
  acl_req_type req = '0;
  logic [31:0] rdata;
  logic [31:0] fa = '0;
  logic [31:0] fd = '0;
  logic [31:0] pv = '0;
  logic [31:0] rs = '0;
  acl_pc_type  pk = ACL_PC_NONE;
  acl_rev_type ro = ACL_REV_NONE;
  acl_rsp_type rsp;
  logic        unal, usage, invst, invalid_pc_fault, ffault, pcval, beo;
  logic [31:0] pcn, rres, hw_q, rev_q;
  logic [15:0] h1, h2;
  int          n_fail = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'd89188;
  acl_exp_type q[$];
  acl_exp_type em;

  always #4 mclk_i = ~mclk_i;

  acl_mem_model i_mem (.req_i(req), .rdata_o(rdata));

  acl_core i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .big_endian_mode_i(be_i), .unaligned_trap_enable_i(trap_i),
    .req_i(req), .rdata_i(rdata), .fetch_valid_i(fv),
    .fetch_addr_i(fa), .fetch_data_i(fd), .pc_kind_i(pk),
    .pc_value_i(pv), .rev_op_i(ro), .rev_src_i(rs), .rsp_o(rsp),
    .unaligned_fault_o(unal), .usage_fault_exception_o(usage),
    .invalid_state_fault_o(invst), .invalid_pc_fault_o(invalid_pc_fault),
    .fetch_fault_o(ffault), .pc_next_o(pcn), .pc_valid_o(pcval),
    .first_halfword_o(h1), .second_halfword_o(h2),
    .rev_result_o(rres), .big_endian_mode_o(beo));

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] o, input logic [63:0] e);
    check_count++;
    if (o !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, o, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset(input logic be);
    @(posedge mclk_i);
    #1 resetn_i = 0;
    req.valid = 0;
    fv = 0;
    pk = ACL_PC_NONE;
    ro = ACL_REV_NONE;
    be_i = be;
    be_s = be;
    hw_q = '0;
    rev_q = '0;
    repeat (16) @(posedge mclk_i);
    #1 resetn_i = 1;
    @(posedge mclk_i);
    #1 be_i = !be;
    check(64'(beo), 64'(be));
  endtask

  // ==========================================================
  // Driver: one random request of every kind each cycle.
  task automatic step();
    acl_exp_type e;
    logic [31:0] r, a, v;
    logic        mis, f, big, st, pc;
    r = rnd();
    a = rnd();
    if (r[3:0] == 4'h0) a = {20'hE_000E, a[11:0]};
    req = '{1'b1, r[4], acl_class_type'(r[31:16] % 10), a, rnd()};
    trap_i = r[5];
    fv = 1;
    fa = rnd();
    fd = rnd();
    pk = acl_pc_type'(r[15:8] % 5);
    pv = rnd();
    if (pk == ACL_PC_EXCEPTION_RETURN_CODE) pv[31:4] = ACL_EXCRET_TOP;
    ro = acl_rev_type'(r[7:6]);
    rs = rnd();
    @(posedge mclk_i);
    e = '0;
    v = req.is_load ? rdata : req.wdata;
    big = be_s && ((a & ACL_SCS_MASK) != ACL_SCS_BASE);
    case (req.cls)
      ACL_BYTE: begin
        e.rsp.lanes = ACL_LANES_BYTE;
        v = {24'h00_0000, v[7:0]};
        mis = 0;
      end
      ACL_HALF, ACL_TBH, ACL_EXCL_HALF: begin
        e.rsp.lanes = ACL_LANES_HALF;
        v = big ? {16'h0000, v[7:0], v[15:8]} : {16'h0000, v[15:0]};
        mis = a[0];
      end
      default: begin
        e.rsp.lanes = ACL_LANES_WORD;
        if (big) v = {v[7:0], v[15:8], v[23:16], v[31:24]};
        mis = a[1:0] != 2'h0;
      end
    endcase
    f = mis && (trap_i || req.cls inside {ACL_EXCL_HALF, ACL_EXCL_WORD,
        ACL_DOUBLE, ACL_MULTI, ACL_STACK, ACL_COPROC});
    e.rsp.valid = 1;
    e.rsp.fault = f;
    e.rsp.perform = !f;
    if (f) e.rsp.lanes = ACL_LANES_NONE;
    e.rsp.data = f ? ACL_ZERO_WORD : v;
    case (ro)
      ACL_REV_WORD: rev_q = {rs[7:0], rs[15:8], rs[23:16], rs[31:24]};
      ACL_REV_SIGNED_HALF: rev_q = {{16{rs[7]}}, rs[7:0], rs[15:8]};
      ACL_REV_PACKED_HALVES: rev_q = {rs[23:16], rs[31:24], rs[7:0], rs[15:8]};
      default: rev_q = rev_q;
    endcase
    e.byte_reverse_word = rev_q;
    if (!fa[0]) hw_q = fd;
    e.hw = hw_q;
    st = (pk == ACL_PC_VECTOR || pk == ACL_PC_INTERWORK) && !pv[0];
    pc = pk == ACL_PC_EXCEPTION_RETURN_CODE && !(pv[3:0] inside
         {ACL_EXCRET_HND, ACL_EXCRET_MSP, ACL_EXCRET_PSP});
    e.flg = {f, f | st | pc | fa[0], st, pc, fa[0]};
    e.pcv = pk == ACL_PC_ADDMOV16;
    e.pck = pk inside {ACL_PC_NONE, ACL_PC_ADDMOV16, ACL_PC_EXCEPTION_RETURN_CODE};
    e.pc = e.pcv ? {pv[31:1], 1'b0} : 32'h0000_0000;
    q.push_back(e);
    #1;
  endtask

  // Monitor: compares each registered answer with the oldest note.
  always @(negedge mclk_i) begin
    if (q.size() > 0) begin
      em = q.pop_front();
      check(64'(rsp), 64'(em.rsp));
      check(64'({unal, usage, invst, invalid_pc_fault, ffault}), 64'(em.flg));
      check(64'(rres), 64'(em.byte_reverse_word));
      check(64'({h2, h1}), 64'(em.hw));
      check({em.pck & pcval, em.pcv ? pcn : 32'h0}, {em.pcv, em.pc});
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end

  initial begin
    do_reset(1'b0);
    repeat (400) step();
    $display("test little endian done");
    do_reset(1'b1);
    repeat (400) step();
    $display("test big endian done");
    repeat (2) @(posedge mclk_i);
    give_verdict();
  end
endmodule
